/* File: core/sfm_pkg.sv */
package sfm_pkg;

  // Command codes
  localparam logic [7:0] CMD_RDSR1 = 8'h05;
  localparam logic [7:0] CMD_RDSR2 = 8'h35;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_RDCFG = 8'h65;
  localparam logic [7:0] CMD_WRCFG = 8'h71;
  localparam logic [7:0] CMD_EN4B = 8'hB7;
  localparam logic [7:0] CMD_RSTEN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_QREAD = 8'hEB;
  localparam logic [7:0] CMD_QREAD4 = 8'hEC;

  // Mode bits: upper nibble that keeps continuous read
  localparam logic [3:0] XIP_NIBBLE = 4'hA;
  // Clocks of all-ones on the four lines that force continuous read off
  localparam logic [3:0] XIP_EXIT_CLOCKS = 4'h8;

  localparam logic [31:0] CFG_ADDR = 32'h0080_0003;
  localparam int QCM_BIT = 6;
  localparam int QE_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Phase lengths in bits
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_WRSR = 6'h10;
  localparam logic [5:0] LEN_ADDR3 = 6'h18;
  localparam logic [5:0] LEN_ADDR4 = 6'h20;

  typedef struct packed {
    logic csN;
    logic sck;
    logic [3:0] dq;
  } sfm_pins_t;

  typedef struct packed {
    logic xip;
    logic qpi;
    logic addr4;
    logic qe;
    logic wel;
  } sfm_mode_t;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_MODE = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_IGNORE = 3'b101
  } sfm_state_t;

  typedef enum logic [1:0] {
    OP_WRSR = 2'b00,
    OP_WRCFG = 2'b01,
    OP_RDCFG = 2'b10,
    OP_QREAD = 2'b11
  } sfm_op_t;

endpackage : sfm_pkg

/* File: core/sfm_pin_sync.sv */
`timescale 1ns/100ps
module sfm_pin_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire sfm_pkg::sfm_pins_t pins,
  output sfm_pkg::sfm_pins_t pinsS,
  output logic sckRise,
  output logic sckFall,
  output logic csFall,
  output logic csRise
);

  localparam sfm_pkg::sfm_pins_t IDLE = '{csN: 1'b1, sck: 1'b0, dq: 4'h0};

  sfm_pkg::sfm_pins_t meta_q;
  sfm_pkg::sfm_pins_t sync_q;
  sfm_pkg::sfm_pins_t last_q;

  // First stage feeds only the second; edges come from stages two and three
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
      last_q <= IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign pinsS = sync_q;
  assign sckRise = sync_q.sck & ~last_q.sck;
  assign sckFall = ~sync_q.sck & last_q.sck;
  assign csFall = ~sync_q.csN & last_q.csN;
  assign csRise = sync_q.csN & ~last_q.csN;

endmodule : sfm_pin_sync

/* File: core/sfm_mode_control.sv */
// What this block does
// - Command 05h returns the first status register.
// - Command 35h returns the second status register.
// - Write-status 01h with second byte bit 1 set sets quad enable.
// - Write-status with second byte bit 1 clear clears quad enable.
// - Mode bits Axh after address enter continuous quad read.
// - Mode bits not Axh leave continuous read when the read ends.
// - Eight clocks of Fh on four lines force continuous read off.
// - Config bit 6 at 800003h enables quad command mode, volatile only.
// - Read 65h, clear bit 6, write 71h at 800003h leaves quad mode.
// - Software reset pair also returns to single-line command mode.
// - Command B7h selects four-byte addressing, no write enable needed.
// - Dedicated commands take four address bytes; continuous frames after them use the current addressing width.
// - Hardware reset, software reset or power cycle restore three-byte addressing.
// - Software reset happens only after 66h immediately followed by 99h.
// - Reset pair accepted on the line width of the current mode.
// - First status register mixes volatile and non-volatile bits.
// - Status writes need a preceding 06h write enable, else ignored.
`timescale 1ns/100ps
module sfm_mode_control (
  input wire logic mclk,
  input wire logic rst,
  input wire sfm_pkg::sfm_pins_t pins,
  input wire logic [7:0] sr1NvInit,
  input wire logic [7:0] sr2NvInit,
  input wire logic busy,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe,
  output sfm_pkg::sfm_mode_t modeState,
  output logic [7:0] sr1Bits,
  output logic [7:0] sr2Bits,
  output logic [7:0] cfgBits,
  output logic readReq,
  output logic [31:0] readAddr
);

  sfm_pkg::sfm_pins_t pinsS;
  logic sckRise;
  logic sckFall;
  logic csFall;
  logic csRise;

  sfm_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pins(pins),
    .pinsS(pinsS),
    .sckRise(sckRise),
    .sckFall(sckFall),
    .csFall(csFall),
    .csRise(csRise)
  );

  function automatic logic [5:0] addrLen(input logic four);
    addrLen = four ? sfm_pkg::LEN_ADDR4 : sfm_pkg::LEN_ADDR3;
  endfunction : addrLen

  function automatic logic [5:0] laneStep(input logic quad);
    laneStep = quad ? 6'h04 : 6'h01;
  endfunction : laneStep

  sfm_pkg::sfm_state_t state_q, state_d;
  sfm_pkg::sfm_op_t op_q, op_d;
  logic [31:0] inSr_q, inSr_d;
  logic [5:0] bitCnt_q, bitCnt_d;
  logic [5:0] need_q, need_d;
  logic quadPh_q, quadPh_d;
  logic [3:0] clkCnt_q, clkCnt_d;
  logic allOnes_q, allOnes_d;
  logic [31:0] addr_q, addr_d;
  logic [7:0] outSr_q, outSr_d;
  logic [7:0] rdByte_q, rdByte_d;
  logic [2:0] outCnt_q, outCnt_d;
  logic [3:0] dqOut_q, dqOut_d;
  logic [3:0] dqOe_q, dqOe_d;
  logic xip_q, xip_d;
  logic keepXip_q, keepXip_d;
  logic addr4_q, addr4_d;
  logic wel_q, wel_d;
  logic rstArm_q, rstArm_d;
  logic [7:2] sr1Nv_q, sr1Nv_d;
  logic [7:0] sr2_q, sr2_d;
  logic [7:0] cfg_q, cfg_d;
  logic readReq_q, readReq_d;
  logic [31:0] readAddr_q, readAddr_d;
  logic [7:0] sr1;
  logic qpi;
  logic phaseDone;
  logic [5:0] cntNext;
  logic [31:0] shifted;

  assign qpi = cfg_q[sfm_pkg::QCM_BIT];
  assign sr1 = {sr1Nv_q, wel_q, busy};
  assign cntNext = bitCnt_q + laneStep(quadPh_q);
  assign shifted = quadPh_q ? {inSr_q[27:0], pinsS.dq} : {inSr_q[30:0], pinsS.dq[0]};
  assign phaseDone = ~pinsS.csN && sckRise && cntNext == need_q
    && state_q != sfm_pkg::ST_READ && state_q != sfm_pkg::ST_IGNORE;

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    inSr_d = inSr_q;
    bitCnt_d = bitCnt_q;
    need_d = need_q;
    quadPh_d = quadPh_q;
    clkCnt_d = clkCnt_q;
    allOnes_d = allOnes_q;
    addr_d = addr_q;
    outSr_d = outSr_q;
    rdByte_d = rdByte_q;
    outCnt_d = outCnt_q;
    dqOut_d = dqOut_q;
    dqOe_d = dqOe_q;
    xip_d = xip_q;
    keepXip_d = keepXip_q;
    addr4_d = addr4_q;
    wel_d = wel_q;
    rstArm_d = rstArm_q;
    sr1Nv_d = sr1Nv_q;
    sr2_d = sr2_q;
    cfg_d = cfg_q;
    readReq_d = 1'b0;
    readAddr_d = readAddr_q;
    if (csFall) begin
      bitCnt_d = 6'h00;
      inSr_d = 32'h0;
      clkCnt_d = 4'h0;
      allOnes_d = 1'b1;
      keepXip_d = xip_q;
      if (xip_q) begin
        // No command byte: the transfer opens straight with the address
        state_d = sfm_pkg::ST_ADDR;
        op_d = sfm_pkg::OP_QREAD;
        need_d = addrLen(addr4_q);
        quadPh_d = 1'b1;
      end else begin
        state_d = sfm_pkg::ST_CMD;
        need_d = sfm_pkg::LEN_BYTE;
        quadPh_d = qpi;
      end
    end else if (csRise) begin
      state_d = sfm_pkg::ST_IGNORE;
      dqOe_d = 4'h0;
      xip_d = keepXip_q;
    end else if (~pinsS.csN && sckFall && state_q == sfm_pkg::ST_READ) begin
      outCnt_d = outCnt_q + (qpi ? 3'h4 : 3'h1);
      if (qpi) begin
        dqOut_d = outSr_q[7:4];
        dqOe_d = 4'hF;
        outSr_d = {outSr_q[3:0], 4'h0};
      end else begin
        dqOut_d = {2'b00, outSr_q[7], 1'b0};
        dqOe_d = 4'h2;
        outSr_d = {outSr_q[6:0], 1'b0};
      end
      // Repeats the byte for as long as the host keeps clocking
      if (outCnt_d == 3'h0) begin
        outSr_d = rdByte_q;
      end
    end else if (~pinsS.csN && sckRise && state_q != sfm_pkg::ST_READ
                 && state_q != sfm_pkg::ST_IGNORE) begin
      inSr_d = shifted;
      bitCnt_d = cntNext;
      if (xip_q && clkCnt_q != sfm_pkg::XIP_EXIT_CLOCKS) begin
        clkCnt_d = clkCnt_q + 4'h1;
        allOnes_d = allOnes_q & (&pinsS.dq);
        if (clkCnt_d == sfm_pkg::XIP_EXIT_CLOCKS && allOnes_d) begin
          xip_d = 1'b0;
          keepXip_d = 1'b0;
          state_d = sfm_pkg::ST_IGNORE;
        end
      end
      if (phaseDone && state_d != sfm_pkg::ST_IGNORE) begin
        bitCnt_d = 6'h00;
        inSr_d = 32'h0;
        case (state_q)
          sfm_pkg::ST_CMD: begin
            state_d = sfm_pkg::ST_IGNORE;
            rstArm_d = 1'b0;
            case (shifted[7:0])
              sfm_pkg::CMD_RDSR1: begin
                state_d = sfm_pkg::ST_READ;
                outSr_d = sr1;
                rdByte_d = sr1;
                outCnt_d = 3'h0;
              end
              sfm_pkg::CMD_RDSR2: begin
                state_d = sfm_pkg::ST_READ;
                outSr_d = sr2_q;
                rdByte_d = sr2_q;
                outCnt_d = 3'h0;
              end
              sfm_pkg::CMD_WREN: wel_d = 1'b1;
              sfm_pkg::CMD_WRSR: begin
                if (wel_q) begin
                  state_d = sfm_pkg::ST_WRITE;
                  op_d = sfm_pkg::OP_WRSR;
                  need_d = sfm_pkg::LEN_WRSR;
                end
              end
              sfm_pkg::CMD_RDCFG, sfm_pkg::CMD_WRCFG: begin
                state_d = sfm_pkg::ST_ADDR;
                op_d = shifted[7:0] == sfm_pkg::CMD_RDCFG ? sfm_pkg::OP_RDCFG
                                                          : sfm_pkg::OP_WRCFG;
                need_d = addrLen(addr4_q);
              end
              sfm_pkg::CMD_EN4B: addr4_d = 1'b1;
              sfm_pkg::CMD_RSTEN: rstArm_d = 1'b1;
              sfm_pkg::CMD_RST: begin
                if (rstArm_q) begin
                  addr4_d = 1'b0;
                  cfg_d = sfm_pkg::CFG_RESET;
                  wel_d = 1'b0;
                  xip_d = 1'b0;
                  keepXip_d = 1'b0;
                end
              end
              sfm_pkg::CMD_QREAD, sfm_pkg::CMD_QREAD4: begin
                // Array read is not served unless quad enable is set
                if (sr2_q[sfm_pkg::QE_BIT]) begin
                  state_d = sfm_pkg::ST_ADDR;
                  op_d = sfm_pkg::OP_QREAD;
                  quadPh_d = 1'b1;
                  need_d = addrLen(addr4_q || shifted[7:0] == sfm_pkg::CMD_QREAD4);
                end
              end
              default: state_d = sfm_pkg::ST_IGNORE;
            endcase
          end
          sfm_pkg::ST_ADDR: begin
            addr_d = shifted;
            state_d = sfm_pkg::ST_IGNORE;
            if (op_q == sfm_pkg::OP_QREAD) begin
              state_d = sfm_pkg::ST_MODE;
              need_d = sfm_pkg::LEN_BYTE;
            end else if (shifted == sfm_pkg::CFG_ADDR && op_q == sfm_pkg::OP_RDCFG) begin
              state_d = sfm_pkg::ST_READ;
              outSr_d = cfg_q;
              rdByte_d = cfg_q;
              outCnt_d = 3'h0;
            end else if (shifted == sfm_pkg::CFG_ADDR) begin
              state_d = sfm_pkg::ST_WRITE;
              need_d = sfm_pkg::LEN_BYTE;
            end
          end
          sfm_pkg::ST_MODE: begin
            state_d = sfm_pkg::ST_IGNORE;
            keepXip_d = shifted[7:4] == sfm_pkg::XIP_NIBBLE && sr2_q[sfm_pkg::QE_BIT];
            readReq_d = 1'b1;
            readAddr_d = addr_q;
          end
          sfm_pkg::ST_WRITE: begin
            state_d = sfm_pkg::ST_IGNORE;
            if (op_q == sfm_pkg::OP_WRSR) begin
              wel_d = 1'b0;
              sr1Nv_d = shifted[15:10];
              sr2_d = shifted[7:0];
            end else begin
              cfg_d = shifted[7:0];
            end
          end
          default: state_d = sfm_pkg::ST_IGNORE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= sfm_pkg::ST_IGNORE;
      op_q <= sfm_pkg::OP_WRSR;
      inSr_q <= 32'h0;
      bitCnt_q <= 6'h00;
      need_q <= sfm_pkg::LEN_BYTE;
      quadPh_q <= 1'b0;
      clkCnt_q <= 4'h0;
      allOnes_q <= 1'b0;
      addr_q <= 32'h0;
      outSr_q <= 8'h00;
      rdByte_q <= 8'h00;
      outCnt_q <= 3'h0;
      dqOut_q <= 4'h0;
      dqOe_q <= 4'h0;
      xip_q <= 1'b0;
      keepXip_q <= 1'b0;
      addr4_q <= 1'b0;
      wel_q <= 1'b0;
      rstArm_q <= 1'b0;
      sr1Nv_q <= sr1NvInit[7:2];
      sr2_q <= sr2NvInit;
      cfg_q <= sfm_pkg::CFG_RESET;
      readReq_q <= 1'b0;
      readAddr_q <= 32'h0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      inSr_q <= inSr_d;
      bitCnt_q <= bitCnt_d;
      need_q <= need_d;
      quadPh_q <= quadPh_d;
      clkCnt_q <= clkCnt_d;
      allOnes_q <= allOnes_d;
      addr_q <= addr_d;
      outSr_q <= outSr_d;
      rdByte_q <= rdByte_d;
      outCnt_q <= outCnt_d;
      dqOut_q <= dqOut_d;
      dqOe_q <= dqOe_d;
      xip_q <= xip_d;
      keepXip_q <= keepXip_d;
      addr4_q <= addr4_d;
      wel_q <= wel_d;
      rstArm_q <= rstArm_d;
      sr1Nv_q <= sr1Nv_d;
      sr2_q <= sr2_d;
      cfg_q <= cfg_d;
      readReq_q <= readReq_d;
      readAddr_q <= readAddr_d;
    end
  end

  assign dqOut = dqOut_q;
  assign dqOe = dqOe_q;
  assign modeState = '{xip: xip_q, qpi: qpi, addr4: addr4_q, qe: sr2_q[sfm_pkg::QE_BIT],
                       wel: wel_q};
  assign sr1Bits = sr1;
  assign sr2Bits = sr2_q;
  assign cfgBits = cfg_q;
  assign readReq = readReq_q;
  assign readAddr = readAddr_q;

  logic cmdDone;
  assign cmdDone = phaseDone && state_q == sfm_pkg::ST_CMD;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  rdsr1_load_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_RDSR1
    |=> state_q == sfm_pkg::ST_READ && rdByte_q == $past(sr1))
    else $error("status one not loaded");
  rdsr2_load_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_RDSR2
    |=> rdByte_q == $past(sr2_q))
    else $error("status two not loaded");
  qe_write_a: assert property (phaseDone && state_q == sfm_pkg::ST_WRITE
    && op_q == sfm_pkg::OP_WRSR |=> sr2_q[sfm_pkg::QE_BIT] == $past(shifted[sfm_pkg::QE_BIT]))
    else $error("quad enable not written");
  wrsr_gate_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_WRSR && !wel_q
    |=> state_q == sfm_pkg::ST_IGNORE [*2])
    else $error("status write without enable");
  xip_enter_a: assert property (phaseDone && state_q == sfm_pkg::ST_MODE
    && shifted[7:4] == sfm_pkg::XIP_NIBBLE && sr2_q[sfm_pkg::QE_BIT] |=> keepXip_q)
    else $error("continuous read not armed");
  xip_keep_a: assert property (csRise && keepXip_q |=> xip_q)
    else $error("continuous read not entered");
  xip_leave_a: assert property (csRise && !keepXip_q |=> !xip_q)
    else $error("continuous read not left");
  xip_addr_a: assert property (csFall && xip_q |=> state_q == sfm_pkg::ST_ADDR
    && quadPh_q && op_q == sfm_pkg::OP_QREAD)
    else $error("continuous read did not start with address");
  en4b_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_EN4B |=> addr4_q)
    else $error("four-byte addressing not set");
  soft_reset_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_RST && rstArm_q
    |=> !addr4_q && !qpi && !xip_q)
    else $error("software reset did not act");
  reset_unarmed_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_RST
    && !rstArm_q |=> $stable(addr4_q) && $stable(cfg_q))
    else $error("reset without enable acted");
  hw_reset_a: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !addr4_q && !qpi)
    else $error("hardware reset left wide addressing");
  qread4_len_a: assert property (cmdDone && shifted[7:0] == sfm_pkg::CMD_QREAD4
    && sr2_q[sfm_pkg::QE_BIT] |=> need_q == sfm_pkg::LEN_ADDR4)
    else $error("dedicated command not four bytes");

  xip_cover_c: cover property (xip_q && csFall);
  softrst_cover_c: cover property (cmdDone && shifted[7:0] == sfm_pkg::CMD_RST && rstArm_q);
  qpi_cover_c: cover property (qpi && cmdDone);

endmodule : sfm_mode_control

/* File: bench/sfm_host_model.sv */
`timescale 1ns/100ps
module sfm_host_model (
  input wire logic [3:0] dqOut,
  input wire logic [3:0] dqOe,
  output sfm_pkg::sfm_pins_t pins
);
  logic csN = 1'b1;
  logic sck = 1'b0;
  logic [3:0] hostDq = 4'h0;
  logic [3:0] hostOe = 4'h0;
  // A released line shows the inverse of the last host value, never a stale copy
  always_comb begin
    pins.csN = csN;
    pins.sck = sck;
    for (int i = 0; i < 4; i++) begin
      pins.dq[i] = dqOe[i] ? dqOut[i] : (hostOe[i] ? hostDq[i] : ~hostDq[i]);
    end
  end
  task automatic start();
    csN = 1'b0;
    #24;
  endtask : start
  // Clock stands low between frames
  task automatic stop();
    hostOe = 4'h0;
    #24;
    csN = 1'b1;
    #96;
  endtask : stop
  // Data set while sck is low, taken by the device at the rise
  task automatic send(input logic [31:0] val, input int nbits, input int w);
    for (int i = nbits; i > 0; i -= w) begin
      hostOe = (w == 4) ? 4'hF : 4'h1;
      hostDq = (w == 4) ? val[i-1 -: 4] : {3'h0, val[i-1]};
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask : send
  // Sampled just before the rise; the device updates some 10 to 15 ns after the fall
  task automatic rd(output logic [7:0] b, input int w);
    hostOe = 4'h0;
    b = 8'h00;
    for (int i = 0; i < 8; i += w) begin
      #24 b = (w == 4) ? {b[3:0], pins.dq} : {b[6:0], pins.dq[1]};
      sck = 1'b1;
      #24 sck = 1'b0;
    end
  endtask : rd
endmodule : sfm_host_model

/* File: bench/sfm_mode_control_test.sv */
`timescale 1ns/100ps
module sfm_mode_control_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic busy = 1'b1;
  logic [7:0] sr1NvInit = 8'hA7;
  logic [7:0] sr2NvInit = 8'h50;
  sfm_pkg::sfm_pins_t pins;
  logic [3:0] dqOut;
  logic [3:0] dqOe;
  sfm_pkg::sfm_mode_t modeState;
  logic [7:0] sr1Bits;
  logic [7:0] sr2Bits;
  logic [7:0] cfgBits;
  logic readReq;
  logic [31:0] readAddr;
  logic [31:0] lastAddr = 32'h0;
  logic [7:0] rb;
  int reqs = 0;
  int bad_count = 0;
  int checked = 0;

  sfm_mode_control dut (.mclk(mclk), .rst(rst), .pins(pins), .sr1NvInit(sr1NvInit),
    .sr2NvInit(sr2NvInit), .busy(busy), .dqOut(dqOut), .dqOe(dqOe), .modeState(modeState),
    .sr1Bits(sr1Bits), .sr2Bits(sr2Bits), .cfgBits(cfgBits), .readReq(readReq),
    .readAddr(readAddr));
  sfm_host_model host (.dqOut(dqOut), .dqOe(dqOe), .pins(pins));

  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge mclk) begin
    if (readReq === 1'b1) begin
      reqs <= reqs + 1;
      lastAddr <= readAddr;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic cmd(input logic [7:0] c, input int w);
    host.start();
    host.send({24'h0, c}, 8, w);
    host.stop();
  endtask : cmd
  task automatic rdCmd(input logic [7:0] c, input int w, output logic [7:0] b);
    host.start();
    host.send({24'h0, c}, 8, w);
    host.rd(b, w);
    host.stop();
  endtask : rdCmd
  task automatic wrsr(input logic [15:0] v, input bit en);
    if (en) begin
      cmd(8'h06, 1);
    end
    host.start();
    host.send(32'h01, 8, 1);
    host.send({16'h0, v}, 16, 1);
    host.stop();
  endtask : wrsr
  // Continuous-read frames carry no command byte
  task automatic qread(input logic [7:0] c, input logic [31:0] a, input int na,
    input logic [7:0] mb, input bit withCmd);
    host.start();
    if (withCmd) begin
      host.send({24'h0, c}, 8, 1);
    end
    host.send(a, na, 4);
    host.send({24'h0, mb}, 8, 4);
    host.stop();
  endtask : qread
  task automatic cfgWr(input logic [23:0] a, input logic [7:0] d, input int w);
    host.start();
    host.send(32'h71, 8, w);
    host.send({8'h0, a}, 24, w);
    host.send({24'h0, d}, 8, w);
    host.stop();
  endtask : cfgWr

  initial begin
    #400000;
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(modeState, 5'h00);
    chk(sr2Bits, 8'h50);
    rdCmd(8'h05, 1, rb);
    chk(rb, 8'hA5);
    @(negedge mclk) busy = 1'b0;
    rdCmd(8'h35, 1, rb);
    chk(rb, 8'h50);
    wrsr(16'hFC02, 1'b0);
    chk(sr2Bits, 8'h50);
    cmd(8'h06, 1);
    rdCmd(8'h05, 1, rb);
    chk(rb, 8'hA6);
    host.start();
    host.send(32'h01, 8, 1);
    host.send(32'hFC02, 16, 1);
    host.stop();
    chk(modeState.qe, 1'b1);
    chk(sr2Bits, 8'h02);
    chk(sr1Bits, 8'hFC);
    chk(modeState.wel, 1'b0);
    wrsr(16'hFC00, 1'b1);
    chk(modeState.qe, 1'b0);
    qread(8'hEB, 32'h123456, 24, 8'hA5, 1'b1);
    chk(reqs, 0);
    chk(modeState.xip, 1'b0);
    wrsr(16'hFC02, 1'b1);
    qread(8'hEB, 32'h123456, 24, 8'hA5, 1'b1);
    chk(reqs, 1);
    chk(lastAddr, 32'h123456);
    chk(modeState.xip, 1'b1);
    qread(8'h00, 32'hABCDEF, 24, 8'hA0, 1'b0);
    chk(lastAddr, 32'hABCDEF);
    chk(modeState.xip, 1'b1);
    qread(8'h00, 32'h111111, 24, 8'h00, 1'b0);
    chk(reqs, 3);
    chk(modeState.xip, 1'b0);
    qread(8'hEB, 32'h222222, 24, 8'hA5, 1'b1);
    chk(modeState.xip, 1'b1);
    host.start();
    host.send(32'hFFFFFFFF, 32, 4);
    host.stop();
    chk(modeState.xip, 1'b0);
    rdCmd(8'h35, 1, rb);
    chk(rb, 8'h02);
    qread(8'hEC, 32'h89ABCDEF, 32, 8'h00, 1'b1);
    chk(lastAddr, 32'h89ABCDEF);
    cmd(8'hB7, 1);
    chk(modeState.addr4, 1'b1);
    qread(8'hEB, 32'h01020304, 32, 8'h00, 1'b1);
    chk(lastAddr, 32'h01020304);
    cmd(8'h66, 1);
    rdCmd(8'h05, 1, rb);
    cmd(8'h99, 1);
    chk(modeState.addr4, 1'b1);
    cmd(8'h66, 1);
    cmd(8'h99, 1);
    chk(modeState.addr4, 1'b0);
    cfgWr(24'h800002, 8'h40, 1);
    chk(cfgBits, 8'h00);
    cfgWr(24'h800003, 8'h40, 1);
    chk(modeState.qpi, 1'b1);
    chk(cfgBits, 8'h40);
    host.start();
    host.send(32'h65, 8, 4);
    host.send(32'h800003, 24, 4);
    host.rd(rb, 4);
    host.stop();
    chk(rb, 8'h40);
    cfgWr(24'h800003, 8'h00, 4);
    chk(modeState.qpi, 1'b0);
    cfgWr(24'h800003, 8'h40, 1);
    cmd(8'hB7, 4);
    chk(modeState.addr4, 1'b1);
    cmd(8'h66, 4);
    cmd(8'h99, 4);
    chk(modeState.qpi, 1'b0);
    chk(cfgBits, 8'h00);
    chk(modeState.addr4, 1'b0);
    cmd(8'hB7, 1);
    @(negedge mclk) rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(modeState.addr4, 1'b0);
    chk(sr2Bits, 8'h50);
    end_sim();
  end
endmodule : sfm_mode_control_test
